/* logic/sdtl_core.sv */
// supervisor trap delegation, status view and supervisor interrupt enables
`timescale 1ns/1ns
module sdtl_core
    import sdtl_pkg::*;
#(
    parameter int unsigned LOCAL_IRQ_COUNT = 16
)(
    // clock and reset
    input  wire logic                        CLK_I,
    input  wire logic                        RST_I,
    // csr access
    input  wire sdtl_csr_req_t               CSR_REQ_I,
    output logic                             CSR_ACK_O,
    output logic                             CSR_ERR_O,
    output logic [63:0]                      CSR_RDATA_O,
    // hart state and trap entry
    input  wire logic [1:0]                  PRIV_I,
    input  wire sdtl_trap_req_t              TRAP_REQ_I,
    output logic                             TRAP_DONE_O,
    output logic                             TRAP_SUPER_O,
    output logic [63:0]                      TRAP_PC_O,
    // local interrupt levels and supervisor interrupt request
    input  wire logic [LOCAL_IRQ_COUNT-1:0]  LOCAL_IRQ_I,
    output logic                             SUPER_IRQ_O,
    output logic [5:0]                       SUPER_IRQ_CODE_O
);

    localparam logic [63:0] LOCAL_MASK  = sdtl_local_mask(LOCAL_IRQ_COUNT);
    localparam logic [63:0] IDELEG_MASK = STD_IRQ_MASK | LOCAL_MASK;
    localparam logic [63:0] SUP_EN_MASK = STD_IRQ_MASK | LOCAL_MASK;

    // architectural state
    logic [63:0] ideleg_reg;
    logic [63:0] edeleg_reg;
    logic [63:0] sup_en_reg;
    logic [63:0] sip_reg;
    logic [63:0] scause_reg;
    logic [61:0] stvec_base_reg;
    logic [1:0]  stvec_mode_reg;
    logic        st_sup_ie_reg;
    logic        st_prior_ie_reg;
    logic        st_prior_priv_reg;
    logic        st_mie_reg;
    logic        st_mpie_reg;
    logic [1:0]  st_mpp_reg;

    // derived views and decode
    logic [63:0] mstatus_view;
    logic [63:0] sup_view;
    logic [63:0] pend_all;
    logic [63:0] rdata_next;
    logic        hit;
    logic        wr;
    logic        trap_deleg;
    logic        trap_take;
    logic [63:0] trap_pc_next;
    logic [63:0] irq_ready;
    logic        irq_global;
    logic [5:0]  irq_code_next;

    // one status store feeds both views, so no write can leave them apart
    always_comb
    begin
        mstatus_view              = 64'h0;
        mstatus_view[ST_SUP_IE]     = st_sup_ie_reg;
        mstatus_view[ST_MIE]        = st_mie_reg;
        mstatus_view[ST_PRIOR_IE]   = st_prior_ie_reg;
        mstatus_view[ST_MPIE]       = st_mpie_reg;
        mstatus_view[ST_PRIOR_PRIV] = st_prior_priv_reg;
        mstatus_view[ST_MPP +: 2]   = st_mpp_reg;
    end
    assign sup_view = mstatus_view & SUP_VIEW_MASK;

    // local levels are live; standard pending bits come from software
    assign pend_all = sip_reg | ({{(64-LOCAL_IRQ_COUNT){1'b0}}, LOCAL_IRQ_I} << LOCAL_BASE);

    // read mux and address decode
    always_comb
    begin
        hit        = 1'b1;
        rdata_next = 64'h0;
        unique case (CSR_REQ_I.addr)
            CSR_SUP_STATUS: rdata_next = sup_view;
            CSR_MSTATUS:    rdata_next = mstatus_view;
            CSR_SUP_IRQ_EN: rdata_next = sup_en_reg;
            CSR_SIP:        rdata_next = pend_all;
            CSR_SCAUSE:     rdata_next = scause_reg;
            CSR_STVEC:      rdata_next = {stvec_base_reg, stvec_mode_reg};
            CSR_EDELEG:     rdata_next = edeleg_reg;
            CSR_IDELEG:     rdata_next = ideleg_reg;
            default:     hit = 1'b0;
        endcase
    end
    assign wr = CSR_REQ_I.valid && CSR_REQ_I.write && hit;

    // delegation lookup indexed by cause code
    always_comb
    begin
        trap_deleg = TRAP_REQ_I.irq ? ideleg_reg[TRAP_REQ_I.code]
                                    : edeleg_reg[TRAP_REQ_I.code];
        if (PRIV_I == PRIV_M)
            trap_deleg = 1'b0;
    end
    assign trap_take = TRAP_REQ_I.valid && trap_deleg;

    // trap target: vectored only for interrupts in mode 1
    always_comb
    begin
        trap_pc_next = {stvec_base_reg, 2'b00};
        if (TRAP_REQ_I.irq && stvec_mode_reg == MODE_VECTOR)
            trap_pc_next = {stvec_base_reg, 2'b00} + {56'h0, TRAP_REQ_I.code, 2'b00};
    end

    // csr answer, one cycle after the request
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            CSR_ACK_O   <= 1'b0;
            CSR_ERR_O   <= 1'b0;
            CSR_RDATA_O <= RST_WORD;
        end
        else
        begin
            CSR_ACK_O   <= CSR_REQ_I.valid;
            CSR_ERR_O   <= CSR_REQ_I.valid && !hit;
            CSR_RDATA_O <= CSR_REQ_I.valid ? rdata_next : RST_WORD;
        end
    end

    // delegation masks; reserved bits never take a one
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            ideleg_reg <= RST_WORD;
            edeleg_reg <= RST_WORD;
        end
        else if (wr)
        begin
            if (CSR_REQ_I.addr == CSR_IDELEG)
                ideleg_reg <= CSR_REQ_I.wdata & IDELEG_MASK;
            if (CSR_REQ_I.addr == CSR_EDELEG)
                edeleg_reg <= CSR_REQ_I.wdata & EDELEG_MASK;
        end
    end

    // supervisor enables and software pending bits
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            sup_en_reg <= RST_WORD;
            sip_reg    <= RST_WORD;
        end
        else if (wr)
        begin
            if (CSR_REQ_I.addr == CSR_SUP_IRQ_EN)
                sup_en_reg <= CSR_REQ_I.wdata & SUP_EN_MASK;
            if (CSR_REQ_I.addr == CSR_SIP)
                sip_reg <= CSR_REQ_I.wdata & STD_IRQ_MASK;
        end
    end

    // trap vector; a reserved mode keeps the old one
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            stvec_base_reg <= 62'h0;
            stvec_mode_reg <= MODE_DIRECT;
        end
        else if (wr && CSR_REQ_I.addr == CSR_STVEC)
        begin
            stvec_base_reg <= CSR_REQ_I.wdata[63:2];
            if (CSR_REQ_I.wdata[1:0] <= MODE_VECTOR)
                stvec_mode_reg <= CSR_REQ_I.wdata[1:0];
        end
    end

    // cause; trap entry wins over a software write in the same cycle
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            scause_reg <= RST_WORD;
        else if (trap_take)
            scause_reg <= {TRAP_REQ_I.irq, 57'h0, TRAP_REQ_I.code};
        else if (wr && CSR_REQ_I.addr == CSR_SCAUSE)
            scause_reg <= CSR_REQ_I.wdata;
    end

    // status fields: trap entry stacks enables, else either view writes
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            st_sup_ie_reg     <= 1'b0;
            st_prior_ie_reg   <= 1'b0;
            st_prior_priv_reg <= 1'b0;
            st_mie_reg        <= 1'b0;
            st_mpie_reg       <= 1'b0;
            st_mpp_reg        <= RST_MPP;
        end
        else if (trap_take)
        begin
            st_prior_ie_reg   <= st_sup_ie_reg;
            st_sup_ie_reg     <= 1'b0;
            st_prior_priv_reg <= PRIV_I[0];
        end
        else if (TRAP_REQ_I.valid)
        begin
            st_mpie_reg <= st_mie_reg;
            st_mie_reg  <= 1'b0;
            st_mpp_reg  <= PRIV_I;
        end
        else if (wr && CSR_REQ_I.addr == CSR_SUP_STATUS)
        begin
            st_sup_ie_reg     <= CSR_REQ_I.wdata[ST_SUP_IE];
            st_prior_ie_reg   <= CSR_REQ_I.wdata[ST_PRIOR_IE];
            st_prior_priv_reg <= CSR_REQ_I.wdata[ST_PRIOR_PRIV];
        end
        else if (wr && CSR_REQ_I.addr == CSR_MSTATUS)
        begin
            st_sup_ie_reg     <= CSR_REQ_I.wdata[ST_SUP_IE];
            st_prior_ie_reg   <= CSR_REQ_I.wdata[ST_PRIOR_IE];
            st_prior_priv_reg <= CSR_REQ_I.wdata[ST_PRIOR_PRIV];
            st_mie_reg        <= CSR_REQ_I.wdata[ST_MIE];
            st_mpie_reg       <= CSR_REQ_I.wdata[ST_MPIE];
            st_mpp_reg        <= CSR_REQ_I.wdata[ST_MPP +: 2];
        end
    end

    // trap result toward the fetch unit
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            TRAP_DONE_O  <= 1'b0;
            TRAP_SUPER_O <= 1'b0;
            TRAP_PC_O    <= RST_WORD;
        end
        else
        begin
            TRAP_DONE_O  <= TRAP_REQ_I.valid;
            TRAP_SUPER_O <= trap_take;
            TRAP_PC_O    <= trap_take ? trap_pc_next : RST_WORD;
        end
    end

    // delegated, enabled and pending; user mode ignores the global enable
    assign irq_ready  = pend_all & sup_en_reg & ideleg_reg;
    assign irq_global = (PRIV_I == PRIV_U) || (PRIV_I == PRIV_S && st_sup_ie_reg);

    // highest numbered ready source wins, a simple fixed order
    always_comb
    begin
        irq_code_next = 6'h0;
        for (int unsigned i = 0; i < 64; i++)
        begin
            if (irq_ready[i])
                irq_code_next = i[5:0];
        end
    end

    // supervisor interrupt request, registered
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            SUPER_IRQ_O      <= 1'b0;
            SUPER_IRQ_CODE_O <= 6'h0;
        end
        else
        begin
            SUPER_IRQ_O      <= irq_global && (irq_ready != 64'h0);
            SUPER_IRQ_CODE_O <= irq_code_next;
        end
    end

    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    sequence s_deleg_trap;
        TRAP_REQ_I.valid && trap_deleg;
    endsequence

    sequence s_sup_view_read;
        CSR_REQ_I.valid && !CSR_REQ_I.write && CSR_REQ_I.addr == CSR_SUP_STATUS;
    endsequence

    a_unmapped_answer: assert property (
        CSR_REQ_I.valid && !hit |=> CSR_ACK_O && CSR_ERR_O && CSR_RDATA_O == 64'h0)
        else $error("unmapped csr not refused");
    a_ideleg_reserved: assert property ((ideleg_reg & ~IDELEG_MASK) == 64'h0)
        else $error("reserved interrupt delegation bit set");
    a_edeleg_reserved: assert property ((edeleg_reg & ~EDELEG_MASK) == 64'h0)
        else $error("reserved exception delegation bit set");
    a_view_hides_m: assert property (
        s_sup_view_read |=> (CSR_RDATA_O & ~SUP_VIEW_MASK) == 64'h0)
        else $error("machine field visible in supervisor view");
    a_view_shared: assert property (
        s_sup_view_read |=> CSR_RDATA_O == ($past(mstatus_view) & SUP_VIEW_MASK))
        else $error("status views disagree");
    a_machine_stays: assert property (
        TRAP_REQ_I.valid && PRIV_I == PRIV_M |=> TRAP_DONE_O && !TRAP_SUPER_O)
        else $error("machine mode trap delegated");
    a_not_delegated: assert property (
        TRAP_REQ_I.valid && !(TRAP_REQ_I.irq ? ideleg_reg[TRAP_REQ_I.code]
                                             : edeleg_reg[TRAP_REQ_I.code])
        |=> !TRAP_SUPER_O)
        else $error("undelegated trap sent to supervisor");
    a_deleg_cause: assert property (
        s_deleg_trap |=> TRAP_SUPER_O && scause_reg[CAUSE_IRQ] == $past(TRAP_REQ_I.irq)
                         && scause_reg[5:0] == $past(TRAP_REQ_I.code))
        else $error("supervisor cause wrong");
    a_vector_target: assert property (
        s_deleg_trap ##0 (TRAP_REQ_I.irq && stvec_mode_reg == MODE_VECTOR)
        |=> TRAP_PC_O == {$past(stvec_base_reg), 2'b00} + {56'h0, $past(TRAP_REQ_I.code), 2'b00})
        else $error("vectored target wrong");
    a_enable_stack: assert property (
        s_deleg_trap |=> st_prior_ie_reg == $past(st_sup_ie_reg) && !st_sup_ie_reg)
        else $error("enable not stacked on trap");
    a_global_gate: assert property (
        PRIV_I == PRIV_S && !st_sup_ie_reg |=> !SUPER_IRQ_O)
        else $error("interrupt raised with global enable clear");
    a_pending_write: assert property (
        wr && CSR_REQ_I.addr == CSR_SIP |=> sip_reg == ($past(CSR_REQ_I.wdata) & STD_IRQ_MASK))
        else $error("pending write lost");

endmodule : sdtl_core

/* pkg/sdtl_pkg.sv */
// package: csr numbers, field positions, masks and carriers of the trap delegation block
package sdtl_pkg;

    // csr numbers of the block
    localparam logic [11:0] CSR_SUP_STATUS = 12'h100;
    localparam logic [11:0] CSR_SUP_IRQ_EN = 12'h104;
    localparam logic [11:0] CSR_STVEC      = 12'h105;
    localparam logic [11:0] CSR_SCAUSE     = 12'h142;
    localparam logic [11:0] CSR_SIP        = 12'h144;
    localparam logic [11:0] CSR_MSTATUS    = 12'h300;
    localparam logic [11:0] CSR_EDELEG     = 12'h302;
    localparam logic [11:0] CSR_IDELEG     = 12'h303;

    // status and cause field positions, base bit of the local interrupts
    localparam int unsigned ST_SUP_IE     = 1;
    localparam int unsigned ST_MIE        = 3;
    localparam int unsigned ST_PRIOR_IE   = 5;
    localparam int unsigned ST_MPIE       = 7;
    localparam int unsigned ST_PRIOR_PRIV = 8;
    localparam int unsigned ST_MPP        = 11;
    localparam int unsigned CAUSE_IRQ = 63;
    localparam int unsigned LOCAL_BASE = 16;

    // writable masks
    localparam logic [63:0] SUP_VIEW_MASK = 64'h0000_0000_0000_0122;
    localparam logic [63:0] MSTATUS_MASK  = 64'h0000_0000_0000_19aa;
    localparam logic [63:0] STD_IRQ_MASK  = 64'h0000_0000_0000_0222;
    localparam logic [63:0] EDELEG_MASK   = 64'h0000_0000_0000_b3ff;

    // reset values
    localparam logic [63:0] RST_WORD = 64'h0000_0000_0000_0000;
    localparam logic [1:0]  RST_MPP  = 2'h0;

    // privilege and vector mode encodings
    localparam logic [1:0] PRIV_U = 2'h0;
    localparam logic [1:0] PRIV_S = 2'h1;
    localparam logic [1:0] PRIV_M = 2'h3;
    localparam logic [1:0] MODE_DIRECT = 2'h0;
    localparam logic [1:0] MODE_VECTOR = 2'h1;

    // csr access request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
        logic [63:0] wdata;
    } sdtl_csr_req_t;

    // trap request from the pipeline
    typedef struct packed {
        logic       valid;
        logic       irq;
        logic [5:0] code;
    } sdtl_trap_req_t;

    // bits of the local interrupts above the standard ones
    function automatic logic [63:0] sdtl_local_mask(input int unsigned n);
        logic [63:0] m;
        m = 64'h0;
        for (int unsigned i = 0; i < 64; i++)
        begin
            if (i >= LOCAL_BASE && i < LOCAL_BASE + n)
                m[i] = 1'b1;
        end
        return m;
    endfunction : sdtl_local_mask

endpackage : sdtl_pkg

/* verification/tb.sv */
// self-checking testbench of the supervisor trap delegation block
`timescale 1ns/1ns
module tb;
    import sdtl_pkg::*;

    logic           CLK_I;
    logic           RST_I;
    sdtl_csr_req_t  csr_req;
    sdtl_trap_req_t trap_req;
    logic [1:0]     priv;
    logic [15:0]    local_irq;
    logic           ack;
    logic           err;
    logic [63:0]    rdata;
    logic           done;
    logic           super_o;
    logic [63:0]    pc;
    logic           irq_o;
    logic [5:0]     irq_code;
    int             fails;
    int             num_checks;

    sdtl_core #(.LOCAL_IRQ_COUNT(16)) u_dut (
        .CLK_I(CLK_I), .RST_I(RST_I), .CSR_REQ_I(csr_req), .CSR_ACK_O(ack),
        .CSR_ERR_O(err), .CSR_RDATA_O(rdata), .PRIV_I(priv), .TRAP_REQ_I(trap_req),
        .TRAP_DONE_O(done), .TRAP_SUPER_O(super_o), .TRAP_PC_O(pc),
        .LOCAL_IRQ_I(local_irq), .SUPER_IRQ_O(irq_o), .SUPER_IRQ_CODE_O(irq_code)
    );

    // 25 MHz core clock
    always #20 CLK_I = ~CLK_I;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    // one csr access; request held until the taking edge, answer read just after that same edge
    task automatic csr(input logic wr, input logic [11:0] addr, input logic [63:0] wd,
                       input logic exp_err, output logic [63:0] rd);
        @(posedge CLK_I);
        #1;
        csr_req = '{valid: 1'b1, write: wr, addr: addr, wdata: wd};
        @(posedge CLK_I);
        #1;
        csr_req = '0;
        check({63'h0, ack}, 64'h1, "csr ack");
        check({63'h0, err}, {63'h0, exp_err}, "csr error flag");
        rd = rdata;
    endtask : csr

    task automatic wr(input logic [11:0] addr, input logic [63:0] wd);
        logic [63:0] d;
        csr(1'b1, addr, wd, 1'b0, d);
    endtask : wr

    task automatic rd_chk(input logic [11:0] addr, input logic [63:0] exp, input string msg);
        logic [63:0] d;
        csr(1'b0, addr, 64'h0, 1'b0, d);
        check(d, exp, msg);
    endtask : rd_chk

    // one trap request; outcome stands only in the cycle after
    task automatic trap(input logic irq, input logic [5:0] code, input logic [1:0] p,
                        input logic exp_sup, input logic [63:0] exp_pc);
        @(posedge CLK_I);
        #1;
        priv = p;
        trap_req = '{valid: 1'b1, irq: irq, code: code};
        @(posedge CLK_I);
        #1;
        trap_req = '0;
        check({63'h0, done}, 64'h1, "trap done");
        check({63'h0, super_o}, {63'h0, exp_sup}, "trap destination");
        check(pc, exp_pc, "trap target");
    endtask : trap

    // reset values, unmapped address, reserved bits of masks
    task automatic t_registers();
        logic [63:0] d;
        rd_chk(12'h303, 64'h0, "irq delegation reset");
        rd_chk(12'h302, 64'h0, "exception delegation reset");
        csr(1'b1, 12'h7c0, '1, 1'b1, d);
        check(d, 64'h0, "unmapped read data");
        wr(12'h303, '1);
        rd_chk(12'h303, 64'h0000_0000_ffff_0222, "irq delegation bits");
        wr(12'h302, '1);
        rd_chk(12'h302, 64'h0000_0000_0000_b3ff, "exception delegation bits");
        csr(1'b1, 12'h104, '1, 1'b0, d);
        csr(1'b0, 12'h104, 64'h0, 1'b0, d);
        check(d, 64'h0000_0000_ffff_0222, "enable mask bits");
    endtask : t_registers

    // status view against machine status
    task automatic t_status();
        wr(12'h300, '1);
        rd_chk(12'h100, 64'h122, "view hides machine fields");
        wr(12'h100, 64'h0);
        rd_chk(12'h300, 64'h1888, "view write reaches machine status");
        wr(12'h100, 64'h120);
        rd_chk(12'h100, 64'h120, "prior enable and privilege");
    endtask : t_status

    // exception codes 0 to 15 each routed by its own delegation bit
    task automatic t_exceptions();
        logic sup;
        wr(12'h105, 64'h1000);
        for (int c = 0; c < 16; c++)
        begin
            sup = (c <= 9) || (c == 12) || (c == 13) || (c == 15);
            trap(1'b0, 6'(c), PRIV_U, sup, sup ? 64'h1000 : 64'h0);
            if (sup)
                rd_chk(12'h142, 64'(c), "exception cause");
        end
        trap(1'b0, 6'd2, PRIV_M, 1'b0, 64'h0);
        wr(12'h302, 64'h0);
        trap(1'b0, 6'd2, PRIV_U, 1'b0, 64'h0);
    endtask : t_exceptions

    // delegated interrupts with vectored target
    task automatic t_irq_traps();
        wr(12'h105, 64'h1001);
        wr(12'h302, '1);
        trap(1'b1, 6'd5, PRIV_S, 1'b1, 64'h1014);
        rd_chk(12'h142, 64'h8000_0000_0000_0005, "interrupt cause");
        trap(1'b1, 6'd9, PRIV_U, 1'b1, 64'h1024);
        trap(1'b1, 6'd3, PRIV_U, 1'b0, 64'h0);
        trap(1'b1, 6'd1, PRIV_M, 1'b0, 64'h0);
        trap(1'b0, 6'd2, PRIV_U, 1'b1, 64'h1000);
    endtask : t_irq_traps

    task automatic wait_irq(input logic exp, input logic [5:0] code, input string msg);
        @(posedge CLK_I);
        @(posedge CLK_I);
        #1;
        check({63'h0, irq_o}, {63'h0, exp}, msg);
        if (exp)
            check({58'h0, irq_code}, {58'h0, code}, "interrupt code");
    endtask : wait_irq

    // pending written by software raises the supervisor interrupt
    task automatic t_irq_out();
        priv = PRIV_S;
        wr(12'h104, '1);
        wr(12'h100, 64'h2);
        wr(12'h144, 64'h2);
        wait_irq(1'b1, 6'd1, "software pending raises");
        local_irq = 16'h1;
        wait_irq(1'b1, 6'd16, "local interrupt wins");
        wr(12'h144, 64'h222);
        rd_chk(12'h144, 64'h1_0222, "pending bits");
        wr(12'h100, 64'h0);
        wait_irq(1'b0, 6'd0, "global enable clear");
        wr(12'h100, 64'h2);
        priv = PRIV_M;
        wait_irq(1'b0, 6'd0, "never toward supervisor in machine");
        local_irq = 16'h0;
    endtask : t_irq_out

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    // main sequence
    initial
    begin
        CLK_I = 1'b0;
        RST_I = 1'b1;
        csr_req = '0;
        trap_req = '0;
        priv = PRIV_U;
        local_irq = 16'h0;
        fails = 0;
        num_checks = 0;
        repeat (4) @(posedge CLK_I);
        #1;
        RST_I = 1'b0;
        t_registers();
        t_status();
        t_exceptions();
        t_irq_traps();
        t_irq_out();
        test_done();
    end

    // watchdog, far beyond the roughly 140 cycles the tests need
    initial
    begin
        #(5000 * 40);
        fails++;
        test_done();
    end

endmodule : tb
